// >>> logic/crv_top.sv
// configuration port, readback stream, start-up sequencer and axi4-lite status
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "crv_defs.svh"

module crv_top #(
    parameter int FRAME_WORDS = 11,  // readback data words per frame after the pad word, device dependent
    parameter bit EXTENDED = 1'b0    // reset value of the interleaved column mode
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cfg_select_n,
    input wire logic cfg_write_n,
    input wire logic [7:0] cfg_din,
    output logic [7:0] cfg_dout,
    output logic cfg_dout_oe_n,
    output logic user_logic_en,
    output logic io_en,
    output logic bram_cfg_owner
);
    // ==========================================
    // byte assembly on the configuration port
    logic [1:0] wr_bcnt_reg;       // byte position within the incoming word
    logic [23:0] wr_shift_reg;     // first three bytes, most significant first
    wire wr_byte = !cfg_select_n && !cfg_write_n;
    wire word_done = wr_byte && (wr_bcnt_reg == `CRV_LAST_BYTE);
    wire [31:0] word_in = {wr_shift_reg, cfg_din};
    // header fields of the word just completed
    wire [2:0] hdr_type = word_in[31:29];
    wire [1:0] hdr_op = word_in[28:27];
    wire [13:0] hdr_addr = word_in[26:13];
    wire [26:0] hdr_cnt1 = {16'h0000, word_in[10:0]};
    wire [26:0] hdr_cnt2 = word_in[26:0];

    // assemble bytes; a partial word is dropped only by reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_bcnt_reg <= 2'h0;
            wr_shift_reg <= 24'h00_0000;
        end else if (wr_byte) begin
            wr_bcnt_reg <= wr_bcnt_reg + 2'h1;
            wr_shift_reg <= {wr_shift_reg[15:0], cfg_din};
        end
    end

    // ==========================================
    // packet parser and configuration registers
    crv_pkg::crv_parse_t state_reg;  // header or data phase
    logic [13:0] addr_reg;           // register addressed by last header
    logic [26:0] wcnt_reg;           // data words still to come
    logic [31:0] far_reg;            // frame address
    logic [31:0] opt_reg;            // options word
    logic [26:0] rd_words_reg;       // readback words still to drive
    logic rd_opt_reg;                // readback serves the options word
    logic [1:0] rd_bcnt_reg;         // byte position of outgoing word
    logic [15:0] frame_reg;          // frame index, zero is the pad frame
    logic [15:0] slot_reg;           // word in frame slot, zero is pad word
    logic [3:0] seq_cnt_reg;         // sequencer clocks remaining
    logic shutdown_reg;              // sequencer left the device shut down

    // a header that starts a read, and its length
    wire hdr_is_t1 = (hdr_type == `CRV_HDR_TYPE_T1);
    wire hdr_is_t2 = (hdr_type == `CRV_HDR_TYPE_T2);
    wire [26:0] hdr_cnt = hdr_is_t1 ? hdr_cnt1 : hdr_cnt2;
    wire [13:0] hdr_reg = hdr_is_t1 ? hdr_addr : addr_reg;
    wire hdr_ok = (state_reg == crv_pkg::CRV_P_HDR) && word_done && (hdr_is_t1 || hdr_is_t2);
    wire rd_start = hdr_ok && (hdr_op == `CRV_OP_READ) && (hdr_cnt != 27'h0);
    wire data_word = (state_reg == crv_pkg::CRV_P_DATA) && word_done;
    wire cmd_wr = data_word && (addr_reg == `CRV_REG_CMD);
    wire cmd_start = cmd_wr && (word_in == `CRV_CMD_START);
    // unknown words such as sync and filler words are simply ignored as headers

    // parser state; write packets consume their data words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= crv_pkg::CRV_P_HDR;
            addr_reg <= 14'h0000;
            wcnt_reg <= 27'h0;
        end else if (hdr_ok) begin
            addr_reg <= hdr_reg;
            wcnt_reg <= hdr_cnt;
            if ((hdr_op == `CRV_OP_WRITE) && (hdr_cnt != 27'h0)) begin
                state_reg <= crv_pkg::CRV_P_DATA;
            end
        end else if (data_word) begin
            wcnt_reg <= wcnt_reg - 27'h1;
            if (wcnt_reg == 27'h1) begin
                state_reg <= crv_pkg::CRV_P_HDR;
            end
        end
    end

    // frame address and options registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            far_reg <= 32'h0000_0000;
            opt_reg <= 32'h0000_0000;
        end else if (data_word) begin
            if (addr_reg == `CRV_REG_FAR) begin
                far_reg <= word_in;
            end
            if (addr_reg == `CRV_REG_OPTIONS) begin
                opt_reg <= word_in;
            end
        end
    end

    // ==========================================
    // start-up / shut-down sequencer
    wire seq_busy = (seq_cnt_reg != 4'h0);
    wire seq_last = (seq_cnt_reg == 4'h1);

    // a start command runs the sequencer for eight clocks, then applies bit 15
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_cnt_reg <= 4'h0;
            shutdown_reg <= 1'b0;
        end else begin
            if (cmd_start) begin
                seq_cnt_reg <= `CRV_SEQ_CLOCKS;
            end else if (seq_busy) begin
                seq_cnt_reg <= seq_cnt_reg - 4'h1;
            end
            if (seq_last) begin
                shutdown_reg <= opt_reg[`CRV_OPT_SHUTDOWN_BIT];
            end
        end
    end

    // ==========================================
    // readback stream
    wire rd_active = (rd_words_reg != 27'h0);
    wire rd_byte = !cfg_select_n && cfg_write_n && rd_active;
    wire rd_word_done = rd_byte && (rd_bcnt_reg == `CRV_LAST_BYTE);
    wire far_is_bram = far_reg[`CRV_FAR_BRAM_BIT];
    // pad frame, pad word, or a block ram frame beyond the column
    wire rd_pad = (frame_reg == 16'h0000) || (slot_reg == 16'h0000) ||
        (far_is_bram && (frame_reg > `CRV_BRAM_FRAMES));
    logic [31:0] pattern_reg;
    // no real configuration memory here: frame words are a seeded, position-tagged pattern
    wire [31:0] frame_word = rd_pad ? 32'h0000_0000 : (pattern_reg ^ {frame_reg, slot_reg});
    wire [31:0] rd_word = rd_opt_reg ? opt_reg : frame_word;
    wire [7:0] rd_byte_val = rd_word[{~rd_bcnt_reg, 3'b000} +: 8];
    wire slot_wrap = (slot_reg == 16'(FRAME_WORDS));

    // stream bookkeeping: words remaining, byte, slot and frame counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_words_reg <= 27'h0;
            rd_opt_reg <= 1'b0;
            rd_bcnt_reg <= 2'h0;
            frame_reg <= 16'h0000;
            slot_reg <= 16'h0000;
        end else if (rd_start) begin
            rd_words_reg <= hdr_cnt;
            rd_opt_reg <= (hdr_reg == `CRV_REG_OPTIONS);
            rd_bcnt_reg <= 2'h0;
            frame_reg <= 16'h0000;
            slot_reg <= 16'h0000;
        end else if (rd_byte) begin
            rd_bcnt_reg <= rd_bcnt_reg + 2'h1;
            if (rd_word_done) begin
                rd_words_reg <= rd_words_reg - 27'h1;
                slot_reg <= slot_wrap ? 16'h0000 : slot_reg + 16'h0001;
                frame_reg <= slot_wrap ? frame_reg + 16'h0001 : frame_reg;
            end
        end
    end

    // pin drivers; the byte leaves one clock after the edge that asks for it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_dout <= 8'h00;
            cfg_dout_oe_n <= 1'b1;
        end else begin
            cfg_dout <= rd_byte ? rd_byte_val : 8'h00;
            cfg_dout_oe_n <= !rd_byte;
        end
    end

    // user side enables and block ram ownership
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            user_logic_en <= 1'b1;
            io_en <= 1'b1;
            bram_cfg_owner <= 1'b0;
        end else begin
            user_logic_en <= seq_last ? !opt_reg[`CRV_OPT_SHUTDOWN_BIT] : !shutdown_reg;
            io_en <= seq_last ? !opt_reg[`CRV_OPT_SHUTDOWN_BIT] : !shutdown_reg;
            bram_cfg_owner <= rd_active && !rd_opt_reg && far_is_bram;
        end
    end

    // ==========================================
    // column placement
    logic ext_mode_reg;  // interleaved column numbering
    wire [7:0] col_addr = far_reg[`CRV_FAR_COL_LSB +: 8];
    wire col_right = col_addr[0];
    // extended parts: odd right of centre, even left, counting outward from one
    wire [7:0] col_pos = ext_mode_reg ? ((col_addr + 8'h01) >> 1) : 8'h00;

    // ==========================================
    // axi4-lite slave
    logic aw_full_reg;
    logic w_full_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [31:0] wmask;  // byte strobes widened to bits
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_mask
            assign wmask[gi*8 +: 8] = {8{wstrb_reg[gi]}};
        end
    endgenerate
    wire wr_commit = aw_full_reg && w_full_reg && !s_axi_bvalid;
    wire wr_ctrl = (awaddr_reg == `CRV_OFF_CTRL);
    wire wr_pat = (awaddr_reg == `CRV_OFF_PATTERN);
    wire [31:0] status_word = {16'h0000, col_pos, 3'b000, col_right, bram_cfg_owner,
        rd_active, seq_busy, shutdown_reg};
    wire ar_hit = (s_axi_araddr == `CRV_OFF_CTRL) || (s_axi_araddr == `CRV_OFF_STATUS) ||
        (s_axi_araddr == `CRV_OFF_PATTERN) || (s_axi_araddr == `CRV_OFF_FAR) ||
        (s_axi_araddr == `CRV_OFF_OPTIONS) || (s_axi_araddr == `CRV_OFF_WORDS);
    wire [31:0] rd_mux =
        (s_axi_araddr == `CRV_OFF_CTRL) ? {31'h0, ext_mode_reg} :
        (s_axi_araddr == `CRV_OFF_STATUS) ? status_word :
        (s_axi_araddr == `CRV_OFF_PATTERN) ? pattern_reg :
        (s_axi_araddr == `CRV_OFF_FAR) ? far_reg :
        (s_axi_araddr == `CRV_OFF_OPTIONS) ? opt_reg :
        (s_axi_araddr == `CRV_OFF_WORDS) ? {5'h00, rd_words_reg} : 32'h0000_0000;

    // write side: address and data taken in either order, answered once both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CRV_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_commit) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // read-only and unmapped offsets answer with an error
                s_axi_bresp <= (wr_ctrl || wr_pat) ? `CRV_RESP_OKAY : `CRV_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // software registers: column mode and readback pattern seed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_mode_reg <= EXTENDED;
            pattern_reg <= 32'h0000_0000;
        end else if (wr_commit) begin
            if (wr_ctrl && wstrb_reg[0]) begin
                ext_mode_reg <= wdata_reg[0];
            end
            if (wr_pat) begin
                pattern_reg <= (pattern_reg & ~wmask) | (wdata_reg & wmask);
            end
        end
    end

    // read side: one word per request, answered the cycle after it is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CRV_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= ar_hit ? `CRV_RESP_OKAY : `CRV_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================
    // assertions
    property p_bram_owner;
        @(posedge aclk) disable iff (!aresetn)
        $rose(bram_cfg_owner) |-> $past(rd_active) && $past(far_is_bram) && !$past(rd_opt_reg);
    endproperty
    a_bram_owner: assert property (p_bram_owner) else $error("block ram taken without readback");

    property p_shut_hold;
        @(posedge aclk) disable iff (!aresetn)
        shutdown_reg && !seq_last |=> !user_logic_en && !io_en && shutdown_reg;
    endproperty
    a_shut_hold: assert property (p_shut_hold) else $error("user logic woke without start-up");

    property p_seq_eight;
        @(posedge aclk) disable iff (!aresetn)
        cmd_start && !seq_busy |=> seq_busy [*8] ##1 !seq_busy;
    endproperty
    a_seq_eight: assert property (p_seq_eight) else $error("sequencer did not run eight clocks");

    property p_startup;
        @(posedge aclk) disable iff (!aresetn)
        seq_last && !opt_reg[`CRV_OPT_SHUTDOWN_BIT] |=> ##1 user_logic_en && io_en && !shutdown_reg;
    endproperty
    a_startup: assert property (p_startup) else $error("start-up did not re-enable user logic");

    property p_drive;
        @(posedge aclk) disable iff (!aresetn)
        rd_byte |=> !cfg_dout_oe_n ##0 (cfg_dout == $past(rd_byte_val));
    endproperty
    a_drive: assert property (p_drive) else $error("readback byte not driven");

    property p_count;
        @(posedge aclk) disable iff (!aresetn)
        rd_word_done && (rd_words_reg == 27'h1) && !rd_start |=> !rd_active ##1 cfg_dout_oe_n;
    endproperty
    a_count: assert property (p_count) else $error("readback ran past its word count");

    property p_pad;
        @(posedge aclk) disable iff (!aresetn)
        rd_byte && !rd_opt_reg && ((frame_reg == 16'h0000) || (slot_reg == 16'h0000)) |=> cfg_dout == 8'h00;
    endproperty
    a_pad: assert property (p_pad) else $error("pad position carried data");

    property p_bram_len;
        @(posedge aclk) disable iff (!aresetn)
        rd_byte && !rd_opt_reg && far_is_bram && (frame_reg > `CRV_BRAM_FRAMES) |=> cfg_dout == 8'h00;
    endproperty
    a_bram_len: assert property (p_bram_len) else $error("data beyond the column frames");
endmodule

// >>> logic/crv_defs.svh
// constants for the configuration port, readback stream and register map
`ifndef CRV_DEFS_SVH
`define CRV_DEFS_SVH
// ==========================================
// packet header fields
`define CRV_HDR_TYPE_T1 3'h1
`define CRV_HDR_TYPE_T2 3'h2
`define CRV_OP_READ 2'h1
`define CRV_OP_WRITE 2'h2
// ==========================================
// configuration register addresses
`define CRV_REG_FAR 14'h0001
`define CRV_REG_RDBK_PORT 14'h0003
`define CRV_REG_CMD 14'h0004
`define CRV_REG_OPTIONS 14'h0009
// ==========================================
// command codes
`define CRV_CMD_RDBK 32'h0000_0004
`define CRV_CMD_START 32'h0000_0005
`define CRV_CMD_CRC_CLEAR 32'h0000_0007
// ==========================================
// options, frame address and sequencing
`define CRV_OPT_SHUTDOWN_BIT 15
`define CRV_FAR_BRAM_BIT 25
`define CRV_FAR_COL_LSB 17
`define CRV_SEQ_CLOCKS 4'h8
`define CRV_BRAM_FRAMES 16'h0041
`define CRV_LAST_BYTE 2'h3
// ==========================================
// axi4-lite byte offsets and responses
`define CRV_OFF_CTRL 8'h00
`define CRV_OFF_STATUS 8'h04
`define CRV_OFF_PATTERN 8'h08
`define CRV_OFF_FAR 8'h0C
`define CRV_OFF_OPTIONS 8'h10
`define CRV_OFF_WORDS 8'h14
`define CRV_RESP_OKAY 2'h0
`define CRV_RESP_SLVERR 2'h2
`endif

// >>> logic/crv_pkg.sv
// types shared by the configuration readback block
package crv_pkg;
    // ==========================================
    // packet parser states
    typedef enum logic [0:0] {
        CRV_P_HDR = 1'b0,  // waiting for a header word
        CRV_P_DATA = 1'b1  // consuming packet data words
    } crv_parse_t;
endpackage

// >>> tb/crv_cfg_host.sv
// controller model that drives the configuration port from outside the device
`timescale 1ns/1ps

module crv_cfg_host (
    input wire logic aclk,
    output logic cfg_select_n,
    output logic cfg_write_n,
    output logic [7:0] cfg_din,
    input wire logic [7:0] cfg_dout,
    input wire logic cfg_dout_oe_n
);
    // ==========================================
    // capture state
    logic [8:0] rx_q[$]; // {oe_n, byte} per readback clock
    logic [31:0] opt_seen; // options word as read back

    // port idle, nothing selected at time zero
    initial begin
        cfg_select_n = 1'h1;
        cfg_write_n = 1'h1;
        cfg_din = 8'h00;
    end

    // ==========================================
    // byte level
    // one word, most significant byte first, one byte per edge
    task automatic send_word(input logic [31:0] w);
        for (int b = 3; b >= 0; b--) begin
            @(posedge aclk);
            cfg_select_n <= 1'h0;
            cfg_write_n <= 1'h0;
            cfg_din <= w[8*b +: 8];
        end
    endtask

    // readback bytes, each looked at in the cycle after its edge
    task automatic read_bytes(input int n);
        @(posedge aclk);
        cfg_select_n <= 1'h0;
        cfg_write_n <= 1'h1;
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            cfg_din <= ~cfg_din; // released lines never hold the last byte
            if (i == n - 1) begin
                cfg_select_n <= 1'h1;
            end
            @(negedge aclk);
            rx_q.push_back({cfg_dout_oe_n, cfg_dout});
        end
    endtask

    // ==========================================
    // command sequences
    // shut-down when down is set, start-up otherwise
    task automatic set_opts(input logic down);
        send_word(32'h2801_2001);
        read_bytes(4);
        opt_seen = {rx_q[0][7:0], rx_q[1][7:0], rx_q[2][7:0], rx_q[3][7:0]};
        rx_q.delete();
        opt_seen[15] = down;
        send_word(32'h3001_2001);
        send_word(opt_seen);
        send_word(32'h3000_8001);
        send_word(32'h0000_0005);
        send_word(32'h3000_8001);
        send_word(32'h0000_0007);
        send_word(32'hFFFF_FFFF);
        send_word(32'hFFFF_FFFF);
        // eight idle clocks with the port released; the sequencer already ran its eight during the words above
        for (int i = 0; i < 8; i++) begin
            @(posedge aclk);
            cfg_select_n <= 1'h1;
            cfg_din <= ~cfg_din;
        end
    endtask

    // one column readback; no sync word, the port is already in step
    task automatic bram_read(input logic [31:0] frame_address_register, input int words, input int extra);
        send_word(32'h3000_2001);
        send_word(frame_address_register);
        send_word(32'h3000_8001);
        send_word(32'h0000_0004);
        send_word(32'h2800_6000);
        send_word(32'h4800_0000 | 32'(words));
        read_bytes(4 * words + extra);
    endtask

    // ==========================================
    // verifier: reference keeps pads ahead of frames, mask keeps them behind
    int vfy_errors; // unmasked bits that differ
    logic vfy_done; // last frame judged
    task automatic verify(input int fw, input int words,
        input logic [31:0] ref_w[$], input logic [31:0] msk_w[$]);
        int r;
        logic [31:0] got;
        vfy_errors = 0;
        vfy_done = 1'h0;
        for (int w = fw + 1; w < words; w++) begin
            r = w - fw - 1;
            if (w % (fw + 1) != 0) begin
                got = {rx_q[4*w][7:0], rx_q[4*w+1][7:0], rx_q[4*w+2][7:0], rx_q[4*w+3][7:0]};
                // the mask's trailing word of each frame is never indexed
                for (int b = 31; b >= 0; b--) begin
                    if (!msk_w[r - 1][b] && got[b] !== ref_w[r][b]) vfy_errors++;
                end
            end
        end
        vfy_done = 1'h1;
    endtask

    // stream bit of a captured state; block ram bits follow every clb frame bit
    function automatic int state_bit(input int frame, input int flen, input int blen, input int offs,
        input int clb_bytes);
        return clb_bytes * 8 + frame * flen + blen - offs + 32;
    endfunction
endmodule

// >>> tb/tb_crv_top.sv
// self-checking testbench for the configuration readback block
`timescale 1ns/1ps
`include "crv_defs.svh"

module tb_crv_top;
    // ==========================================
    // signals
    localparam int FW = 3; // short frames keep readback brief
    localparam logic [31:0] PAT = 32'h1234_5678; // readback seed
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cfg_select_n, cfg_write_n, cfg_dout_oe_n;
    logic user_logic_en, io_en, bram_cfg_owner, owner_ok;
    logic [7:0] s_axi_awaddr, s_axi_araddr, cfg_din, cfg_dout;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int miscompares, checks_done, cycles;

    crv_top #(.FRAME_WORDS(FW)) crv_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .cfg_select_n, .cfg_write_n, .cfg_din, .cfg_dout, .cfg_dout_oe_n, .user_logic_en, .io_en, .bram_cfg_owner);
    crv_cfg_host crv_cfg_host_i (.aclk, .cfg_select_n, .cfg_write_n, .cfg_din, .cfg_dout, .cfg_dout_oe_n);

    // ==========================================
    // clock, watchdog, ownership monitor
    initial begin
        aclk = 1'h0;
        forever #20 aclk = ~aclk;
    end
    // a hang counts as a mismatch
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end
    // any driven byte without block ram ownership clears the flag
    always @(negedge aclk) begin
        if (cfg_dout_oe_n === 1'h0 && bram_cfg_owner !== 1'h1) begin
            owner_ok <= 1'h0;
        end
    end

    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // write: address and data offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'h1) begin
                aw_ok = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'h1) begin
                w_ok = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    // ==========================================
    // scenarios
    // register access, refusals, port quiet after reset
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        check(cfg_dout_oe_n, 1'h1);
        axi_write(`CRV_OFF_PATTERN, PAT, r);
        check(r, `CRV_RESP_OKAY);
        axi_read(`CRV_OFF_PATTERN, d, r);
        check(d, PAT);
        axi_write(`CRV_OFF_CTRL, 32'h0000_0001, r);
        check(r, `CRV_RESP_OKAY);
        axi_read(`CRV_OFF_CTRL, d, r);
        check(d, 32'h0000_0001);
        axi_write(`CRV_OFF_STATUS, 32'hFFFF_FFFF, r);
        check(r, `CRV_RESP_SLVERR);
        axi_read(8'h18, d, r);
        check(r, `CRV_RESP_SLVERR);
        $display("test regs done");
    endtask

    // shut-down, then both columns, then start-up
    task automatic t_bram_session();
        logic [31:0] d;
        logic [1:0] r;
        int w;
        int n;
        logic [31:0] e;
        logic [31:0] rw[$];
        logic [31:0] mw[$];
        // reference: pad, good word, one bit off, all off but masked; mask trailing word ignored
        rw = {32'hFFFF_FFFF, PAT ^ 32'h0001_0001, PAT ^ 32'h0001_0003, ~(PAT ^ 32'h0001_0003)};
        mw = {32'h0000_0000, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000};
        crv_cfg_host_i.set_opts(1'h1);
        @(negedge aclk);
        check(user_logic_en, 1'h0);
        check(io_en, 1'h0);
        axi_read(`CRV_OFF_OPTIONS, d, r);
        check(d[15], 1'h1);
        // third pass runs past the column's last frame
        for (int c = 0; c < 3; c++) begin
            owner_ok = 1'h1;
            n = (c == 2 ? 67 : 2) * (FW + 1);
            // no user write port here, so block ram sees no writes during readback
            crv_cfg_host_i.bram_read(c == 1 ? 32'h0202_0000 : 32'h0200_0000, n, 4);
            for (int i = 0; i < 4 * n + 4; i++) begin
                w = i / 4;
                // pad frame first, then a pad word ahead of each frame
                e = (w < FW + 1 || w % (FW + 1) == 0 || w / (FW + 1) > 65) ? 32'h0000_0000 :
                    PAT ^ {16'(w / (FW + 1)), 16'(w % (FW + 1))};
                e = (w == n) ? 32'h0000_0100 : {24'h00_0000, e[8 * (3 - i % 4) +: 8]};
                check(crv_cfg_host_i.rx_q[i], e);
            end
            crv_cfg_host_i.verify(FW, 2 * (FW + 1), rw, mw);
            check(crv_cfg_host_i.vfy_errors, 32'h0000_0001);
            check(crv_cfg_host_i.vfy_done, 1'h1);
            crv_cfg_host_i.rx_q.delete();
            check(owner_ok, 1'h1);
            check(user_logic_en, 1'h0);
            axi_read(`CRV_OFF_STATUS, d, r);
            check(d, c == 1 ? 32'h0000_0111 : 32'h0000_0001);
        end
        check(crv_cfg_host_i.state_bit(11, 384, 324, 35, 0), 32'h0000_11C1);
        check(crv_cfg_host_i.state_bit(1, 384, 1908, 19, 1000), 32'h0000_2841);
        crv_cfg_host_i.set_opts(1'h0);
        @(negedge aclk);
        check(user_logic_en, 1'h1);
        check(io_en, 1'h1);
        $display("test bram session done");
    endtask

    // ==========================================
    // main sequence
    initial begin
        aresetn = 1'h0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'h0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'h0;
        s_axi_bready = 1'h0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'h0;
        s_axi_rready = 1'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_bram_session();
        summarize();
    end
endmodule
